// ### pairing_cfg.svh
// Timing and encoding constants for the transponder pairing control block
`ifndef PAIRING_CFG_SVH
`define PAIRING_CFG_SVH
`define CLOCK_HZ          20000000
`define WINDOW_SECONDS    10
`define WINDOW_CYCLES     (`WINDOW_SECONDS * `CLOCK_HZ)
`define PAIR_LIMIT        2
`define CODE_WIDTH        32
`define COUNT_WIDTH       2
`define FACTORY_CODE      32'h5a5a_1234
`define EXPECTED_ID       32'h0000_00c3
`endif

// ### pairing_pkg.sv
// Types shared by the transponder pairing control block
`include "pairing_cfg.svh"
package pairing_pkg;
  typedef enum logic [4:0] {
    ST_INIT   = 5'h01,
    ST_WINDOW = 5'h02,
    ST_RUN    = 5'h04,
    ST_PAIRED = 5'h08,
    ST_CLOSED = 5'h10
  } pair_state_e;

  // One transponder as seen in the detection zone
  typedef struct packed {
    logic                     present;
    logic                     blank;
    logic [`CODE_WIDTH-1:0]   id;
    logic [`CODE_WIDTH-1:0]   code;
  } tag_s;

  // Non-volatile image: stored code and count of new pairings
  typedef struct packed {
    logic [`CODE_WIDTH-1:0]   code;
    logic [`COUNT_WIDTH-1:0]  count;
  } nv_image_s;
endpackage

// ### tag_model.sv
// Behavioural transponder that sits in the reader's detection zone
`timescale 1ns/1ps
`include "pairing_cfg.svh"
module tag_model (
  input  wire logic                   i_clock,
  input  wire logic                   i_load,
  input  wire logic                   i_place,
  input  wire logic                   i_blank,
  input  wire logic [`CODE_WIDTH-1:0] i_id,
  input  wire logic                   i_program,
  input  wire logic [`CODE_WIDTH-1:0] i_code,
  output pairing_pkg::tag_s           o_tag,
  output logic                        o_single
);
  import pairing_pkg::*;
  logic                   blank;
  logic [`CODE_WIDTH-1:0] code;
  always_ff @(posedge i_clock) begin
    if (i_load) begin
      blank <= i_blank;
      code  <= i_id;
    end else if (i_program && i_place && blank) begin
      blank <= 1'b0;
      code  <= i_code;
    end
  end
  // Out of range the lines show inverted data, not the last value
  always_comb begin
    if (i_place) o_tag = '{1'b1, blank, i_id, code};
    else o_tag = '{1'b0, ~blank, ~i_id, ~code};
  end
  assign o_single = i_place;
endmodule

// ### transponder_pairing_control.sv
// Pairing control for a contactless safety switch reader
//
// Contract
// - 10 s pairing window after initialization
// - Blank transponder in window pairs automatically
// - New pairing erases previous stored code
// - After pairing, wait for new power-up
// - Reject non-blank or wrong-ID transponder
// - Reject pairing when count reaches 2
// - Unique-pairing variant refuses all new pairings
// - Factory code is the initial reference
// - Transponder is programmed exactly once
`timescale 1ns/1ps
`include "pairing_cfg.svh"
module transponder_pairing_control #(
  parameter int unsigned WINDOW_CYCLES = `WINDOW_CYCLES,
  parameter bit          UNIQUE_ONLY   = 1'b0
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_init_done,
  input  wire logic                    i_nv_valid,
  input  wire pairing_pkg::nv_image_s  i_nv_image,
  input  wire pairing_pkg::tag_s       i_tag,
  input  wire logic                    i_tag_single,
  output logic                         o_nv_write,
  output pairing_pkg::nv_image_s       o_nv_image,
  output logic                         o_tag_program,
  output logic [`CODE_WIDTH-1:0]       o_tag_code,
  output logic                         o_window_open,
  output logic                         o_pair_done,
  output logic                         o_pair_reject,
  output logic                         o_operational,
  output logic                         o_tag_match,
  output logic [`CODE_WIDTH-1:0]       o_active_code,
  output logic [`COUNT_WIDTH-1:0]      o_pair_count
);
  import pairing_pkg::*;

  pair_state_e              state;
  logic [31:0]              win_cnt;
  nv_image_s                image;
  logic                     init_q1;
  logic                     init_q2;
  tag_s                     tag_q1;
  tag_s                     tag_q2;
  tag_s                     tag_q3;
  logic                     tag_steady;
  logic                     single_q1;
  logic                     single_q2;
  logic                     tried;
  logic                     eligible;
  logic                     accept;
  logic                     reject;
  logic [`CODE_WIDTH-1:0]   next_code;

  // Pins from the transponder front end are asynchronous to this clock
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      init_q1   <= 1'b0;
      init_q2   <= 1'b0;
      tag_q1    <= '0;
      tag_q2    <= '0;
      tag_q3    <= '0;
      single_q1 <= 1'b0;
      single_q2 <= 1'b0;
    end else begin
      init_q1   <= i_init_done;
      init_q2   <= init_q1;
      tag_q1    <= i_tag;
      tag_q2    <= tag_q1;
      tag_q3    <= tag_q2;
      single_q1 <= i_tag_single;
      single_q2 <= single_q1;
    end
  end

  // Tag bits are synced one by one; a word caught mid-change must not pair
  assign tag_steady = (tag_q2 == tag_q3);
  // Only a blank, correctly identified lone tag within limits may pair
  assign eligible = tag_q2.present && single_q2 && tag_q2.blank && tag_steady
                  && (tag_q2.id == `EXPECTED_ID)
                  && (image.count < `COUNT_WIDTH'(`PAIR_LIMIT))
                  && !UNIQUE_ONLY;
  assign accept = (state == ST_WINDOW) && eligible;
  assign reject = (state == ST_WINDOW) && tag_q2.present && tag_steady
                  && !eligible && !tried;
  // Fresh code derived from the tag identity and the pairing index
  assign next_code = `FACTORY_CODE ^ tag_q2.id ^ {{(`CODE_WIDTH-`COUNT_WIDTH){1'b0}},
                     image.count + `COUNT_WIDTH'(1)};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state   <= ST_INIT;
      win_cnt <= '0;
    end else begin
      unique case (state)
        ST_INIT: begin
          if (init_q2 && i_nv_valid) begin
            state   <= ST_WINDOW;
            win_cnt <= '0;
          end
        end
        ST_WINDOW: begin
          if (accept) begin
            state <= ST_PAIRED;
          end else if (win_cnt == WINDOW_CYCLES - 1) begin
            state <= ST_RUN;
          end else begin
            win_cnt <= win_cnt + 32'd1;
          end
        end
        // Paired stays parked; only a power-up reset leaves it
        ST_PAIRED: state <= ST_PAIRED;
        ST_RUN:    state <= ST_RUN;
        ST_CLOSED: state <= ST_CLOSED;
        default:   state <= ST_INIT;
      endcase
    end
  end

  // One reject report per tag presence keeps a lingering bad tag from chattering
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tried <= 1'b0;
    end else if (reject) begin
      tried <= 1'b1;
    end else if (!tag_q2.present) begin
      tried <= 1'b0;
    end
  end

  // Working copy of the stored image; reset value is the factory code
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      image.code  <= `FACTORY_CODE;
      image.count <= '0;
    end else if (state == ST_INIT && init_q2 && i_nv_valid) begin
      image <= i_nv_image;
    end else if (accept) begin
      image.code  <= next_code;
      image.count <= image.count + `COUNT_WIDTH'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_nv_write    <= 1'b0;
      o_nv_image    <= '0;
      o_tag_program <= 1'b0;
      o_tag_code    <= '0;
      o_pair_done   <= 1'b0;
      o_pair_reject <= 1'b0;
    end else begin
      o_nv_write    <= accept;
      o_tag_program <= accept;
      o_pair_done   <= accept;
      o_pair_reject <= reject;
      if (accept) begin
        o_nv_image.code  <= next_code;
        o_nv_image.count <= image.count + `COUNT_WIDTH'(1);
        o_tag_code       <= next_code;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tag_match <= 1'b0;
    end else begin
      // Old tag no longer matches once the code is replaced
      o_tag_match <= (state == ST_RUN) && tag_q2.present && !tag_q2.blank
                     && (tag_q2.code == image.code);
    end
  end

  assign o_window_open = (state == ST_WINDOW);
  assign o_operational = (state == ST_RUN);
  assign o_active_code = image.code;
  assign o_pair_count  = image.count;

  property p_window_len;
    @(posedge i_clock) disable iff (i_rst)
      $rose(state == ST_WINDOW) |-> (win_cnt == 32'd0);
  endproperty
  a_window_len: assert property (p_window_len) else $error("window count not cleared");

  property p_window_bound;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_WINDOW) |-> (win_cnt < WINDOW_CYCLES);
  endproperty
  a_window_bound: assert property (p_window_bound) else $error("window overran");

  property p_close_at_end;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_WINDOW && !accept && win_cnt == WINDOW_CYCLES - 1) |=> (state == ST_RUN);
  endproperty
  a_close_at_end: assert property (p_close_at_end) else $error("window did not close");

  property p_auto_pair;
    @(posedge i_clock) disable iff (i_rst)
      accept |=> (o_pair_done && o_tag_program && o_nv_write);
  endproperty
  a_auto_pair: assert property (p_auto_pair) else $error("accepted pairing not done");

  property p_erase_old;
    @(posedge i_clock) disable iff (i_rst)
      accept |=> (image.code == $past(next_code) && o_nv_image.code == $past(next_code));
  endproperty
  a_erase_old: assert property (p_erase_old) else $error("old code kept");

  property p_hold_paired;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_PAIRED) |=> (state == ST_PAIRED && !o_operational);
  endproperty
  a_hold_paired: assert property (p_hold_paired) else $error("left paired without reset");

  property p_reject_bad;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_WINDOW && tag_q2.present && (!tag_q2.blank || tag_q2.id != `EXPECTED_ID))
      |-> !accept;
  endproperty
  a_reject_bad: assert property (p_reject_bad) else $error("bad tag accepted");

  property p_limit;
    @(posedge i_clock) disable iff (i_rst)
      (image.count >= `COUNT_WIDTH'(`PAIR_LIMIT)) |-> !accept;
  endproperty
  a_limit: assert property (p_limit) else $error("pair limit exceeded");

  property p_unique;
    @(posedge i_clock) disable iff (i_rst)
      UNIQUE_ONLY |-> !o_tag_program;
  endproperty
  a_unique: assert property (p_unique) else $error("unique variant paired");

  property p_once;
    @(posedge i_clock) disable iff (i_rst)
      o_tag_program |=> !o_tag_program [*8];
  endproperty
  a_once: assert property (p_once) else $error("tag programmed twice");
endmodule

// ### transponder_pairing_control_bench.sv
// Self-checking bench for the transponder pairing control block
`timescale 1ns/1ps
`include "pairing_cfg.svh"
module transponder_pairing_control_bench;
  import pairing_pkg::*;
  localparam int          WIN = 50;
  localparam logic [31:0] ID  = `EXPECTED_ID;
  localparam logic [31:0] C0  = 32'h0bad_f00d;
  logic        clock = 0, rst = 1, init_done = 0, nv_valid = 1;
  logic        load = 0, place = 0, blank = 0, single, wr, prog, win, done, rej, oper, match;
  logic        u_done, u_rej, u_prog;
  logic [31:0] id = '0, tcode, acode;
  logic [1:0]  cnt;
  nv_image_s   nv = '0, nv_out;
  tag_s        tag;
  int          num_errors = 0, comparisons = 0, n_done = 0, n_rej = 0, n_wr = 0, n_prog = 0;
  int          n_udone = 0, n_urej = 0, n_uprog = 0;
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    n_done += done;
    n_rej  += rej;
    n_wr   += wr;
    n_prog += prog;
    n_udone += u_done;
    n_urej  += u_rej;
    n_uprog += u_prog;
  end
  transponder_pairing_control #(.WINDOW_CYCLES(WIN), .UNIQUE_ONLY(1'b0)) u_dut (
    .i_clock(clock), .i_rst(rst), .i_init_done(init_done), .i_nv_valid(nv_valid),
    .i_nv_image(nv), .i_tag(tag), .i_tag_single(single), .o_nv_write(wr),
    .o_nv_image(nv_out), .o_tag_program(prog), .o_tag_code(tcode), .o_window_open(win),
    .o_pair_done(done), .o_pair_reject(rej), .o_operational(oper), .o_tag_match(match),
    .o_active_code(acode), .o_pair_count(cnt));
  // Unique-pairing variant watches the same tag and must never pair it
  transponder_pairing_control #(.WINDOW_CYCLES(WIN), .UNIQUE_ONLY(1'b1)) u_dut_unique (
    .i_clock(clock), .i_rst(rst), .i_init_done(init_done), .i_nv_valid(nv_valid),
    .i_nv_image(nv), .i_tag(tag), .i_tag_single(single), .o_nv_write(),
    .o_nv_image(), .o_tag_program(u_prog), .o_tag_code(), .o_window_open(),
    .o_pair_done(u_done), .o_pair_reject(u_rej), .o_operational(), .o_tag_match(),
    .o_active_code(), .o_pair_count());
  tag_model u_tag (.i_clock(clock), .i_load(load), .i_place(place), .i_blank(blank),
    .i_id(id), .i_program(prog), .i_code(tcode), .o_tag(tag), .o_single(single));
  task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic power_up(logic [1:0] c, logic [31:0] code);
    @(negedge clock);
    rst = 1;
    init_done = 0;
    place = 0;
    nv = '{code, c};
    repeat (4) @(negedge clock);
    chk("factory_code", `FACTORY_CODE, acode);
    rst = 0;
    init_done = 1;
    for (int k = 0; k < 10 && win !== 1'b1; k++) @(negedge clock);
    chk("window", 1, win);
    chk("count", c, cnt);
    chk("active_code", code, acode);
    {n_done, n_rej, n_wr, n_prog, n_udone, n_urej, n_uprog} = '0;
  endtask
  task automatic place_tag(logic b, logic [31:0] i);
    @(negedge clock);
    load = 1;
    blank = b;
    id = i;
    @(negedge clock);
    load = 0;
    place = 1;
    repeat (8) @(negedge clock);
  endtask
  task automatic present(logic b, logic [31:0] i);
    place_tag(b, i);
    place = 0;
    repeat (4) @(negedge clock);
  endtask
  task automatic t_pair;
    logic [31:0] nc;
    nc = `FACTORY_CODE ^ ID ^ 32'h1;
    power_up(2'h0, C0);
    present(1'b0, ID);
    present(1'b1, ID ^ 32'h1);
    chk("rejects", 2, n_rej);
    chk("window_kept", 1, win);
    present(1'b1, ID);
    chk("done", 1, n_done);
    chk("program", 1, n_prog);
    chk("nv_write", 1, n_wr);
    chk("nv_image", {nc, 2'h1}, nv_out);
    chk("tag_code", nc, tcode);
    chk("window_shut", 0, win);
    present(1'b1, ID);
    chk("done_once", 1, n_done);
    chk("operational", 0, oper);
    power_up(2'h1, nc);
    repeat (WIN + 4) @(negedge clock);
    place_tag(1'b0, nc);
    chk("match_new", 1, match);
    place_tag(1'b0, C0);
    chk("match_old", 0, match);
    place = 0;
  endtask
  task automatic t_limit;
    power_up(2'h2, C0);
    present(1'b1, ID);
    chk("limit_done", 0, n_done);
    chk("limit_reject", 1, n_rej);
  endtask
  task automatic t_unique;
    power_up(2'h0, C0);
    present(1'b1, ID);
    chk("unique_done", 0, n_udone);
    chk("unique_program", 0, n_uprog);
    chk("unique_reject", 1, n_urej);
    chk("standard_done", 1, n_done);
  endtask
  task automatic t_window;
    power_up(2'h0, C0);
    repeat (WIN - 4) @(negedge clock);
    chk("window_late", 1, win);
    repeat (8) @(negedge clock);
    chk("window_over", 0, win);
    chk("run", 1, oper);
    present(1'b1, ID);
    chk("late_done", 0, n_done);
  endtask
  task automatic test_done;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole run is well under a thousand cycles; this only cuts a hang
  initial begin
    repeat (4000) @(posedge clock);
    num_errors++;
    test_done();
  end
  initial begin
    t_pair();
    t_limit();
    t_unique();
    t_window();
    test_done();
  end
endmodule
